// ---- core/acqr_pkg.sv ----
// Notes on behaviour
// R01 - Card query returns number, serial, type
// R02 - Offset and two gains per gain setting
// R03 - Offsets for four cold-junction sensors
// R04 - Card query carries last calibration time/date
// R05 - Absent card reports type minus one
// R06 - Identity, gains, sensors, time/date line order
// R07 - Read type 1 sends oldest scan
// R08 - Read type 2 sends oldest complete block
// R09 - Read type 3 sends every stored scan
// R10 - Acquisition buffer is first-in first-out
// R11 - Read scans leave the buffer
// R12 - Scans queued one at a time, held
// R13 - Host drains queue before next read
// R14 - Too little data flags command conflict
// R15 - Burst mode: 256 samples make a scan
// R16 - Buffer query reports buffer contents
// R17 - Host polls scan-available status bit first
// R18 - Scan terminator per scan, block terminator last
package acqr_pkg;

    // ==========================================================
    // Sizes
    localparam int DATA_W             = 32;
    localparam int ACQ_DEPTH          = 1024;
    localparam int BURST_SCAN_SAMPLES = 256;
    localparam int CARD_NUM_W         = 8;

    // ==========================================================
    // Calibration store layout, one word per entry
    localparam int GAIN_SETTINGS  = 8;
    localparam int CJ_SENSORS     = 4;
    localparam int CAL_MEM_WORDS  = 32;
    localparam int CAL_ADDR_W     = 5;
    localparam int CAL_SERIAL_IDX = 0;
    localparam int CAL_ID_IDX     = 1;
    localparam int CAL_GAIN_IDX   = 2;
    localparam int CAL_CJ_IDX     = CAL_GAIN_IDX + 3 * GAIN_SETTINGS;
    localparam int CAL_TIME_IDX   = CAL_CJ_IDX + CJ_SENSORS;
    localparam int CAL_DATE_IDX   = CAL_TIME_IDX + 1;

    // Response word index: word 0 is the card number, word k+1 is store word k
    localparam int RESP_W         = 6;
    localparam int RESP_LAST      = CAL_MEM_WORDS;

    localparam logic [DATA_W-1:0] CARD_ABSENT_ID = 32'hFFFFFFFF;

    // ==========================================================
    // Read types
    localparam logic [1:0] RTYPE_OLDEST_SCAN  = 2'h1;
    localparam logic [1:0] RTYPE_OLDEST_BLOCK = 2'h2;
    localparam logic [1:0] RTYPE_ALL_SCANS    = 2'h3;

    typedef enum logic [1:0] {
        ACQR_OP_CAL_QUERY,
        ACQR_OP_READ,
        ACQR_OP_BUF_QUERY
    } acqr_op_t;

    typedef struct packed {
        acqr_op_t   op;
        logic [1:0] rtype;
    } acqr_cmd_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              end_scan;
        logic              end_block;
    } acqr_sample_t;

    typedef enum logic [1:0] {
        ACQR_TOK_DATA,
        ACQR_TOK_SCAN_END,
        ACQR_TOK_BLOCK_END,
        ACQR_TOK_LINE_END
    } acqr_kind_t;

    typedef struct packed {
        acqr_kind_t        kind;
        logic [DATA_W-1:0] data;
    } acqr_token_t;

endpackage

// ---- core/acqr_skid.sv ----
module acqr_skid #(
    parameter int W = 34
) (
    input  logic         i_clk,
    input  logic         i_nrst,
    input  logic         i_valid,
    input  logic [W-1:0] i_data,
    output logic         o_ready,
    output logic         o_valid,
    output logic [W-1:0] o_data,
    input  logic         i_ready,
    output logic         o_empty
);

    logic         skid_v;
    logic [W-1:0] skid_d;
    logic         push;
    logic         pop;

    assign o_ready = !skid_v;
    assign o_empty = !o_valid && !skid_v;
    assign push    = i_valid && !skid_v;
    assign pop     = o_valid && i_ready;

    // ==========================================================
    // Head register feeds the port, skid register catches a stalled word
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_valid <= 1'b0;
            skid_v  <= 1'b0;
        end else if (!o_valid || pop) begin
            if (skid_v) begin
                o_valid <= 1'b1;
                skid_v  <= push;
            end else begin
                o_valid <= push;
            end
        end else if (push) begin
            skid_v <= 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!o_valid || pop) begin
            o_data <= skid_v ? skid_d : i_data;
        end
        if (push && (skid_v || (o_valid && !pop))) begin
            skid_d <= i_data;
        end
    end

endmodule

// ---- core/acqr_engine.sv ----
module acqr_engine #(
    parameter int DEPTH = acqr_pkg::ACQ_DEPTH,
    parameter int BURST = acqr_pkg::BURST_SCAN_SAMPLES
) (
    input  logic                                 i_clk,
    input  logic                                 i_nrst,
    input  logic                                 i_cmd_valid,
    input  acqr_pkg::acqr_cmd_t                  i_cmd,
    output logic                                 o_cmd_ready,
    output logic                                 o_conflict,
    input  logic                                 i_acq_valid,
    input  acqr_pkg::acqr_sample_t               i_acq,
    output logic                                 o_acq_ready,
    input  logic                                 i_burst_mode,
    input  logic                                 i_card_present,
    input  logic [acqr_pkg::CARD_NUM_W-1:0]      i_card_num,
    input  logic                                 i_cal_we,
    input  logic [acqr_pkg::CAL_ADDR_W-1:0]      i_cal_addr,
    input  logic [acqr_pkg::DATA_W-1:0]          i_cal_data,
    output logic                                 o_out_valid,
    output acqr_pkg::acqr_token_t                o_out,
    input  logic                                 i_out_ready,
    output logic                                 o_scan_avail,
    output logic [$clog2(DEPTH+1)-1:0]           o_scan_count
);

    localparam int AW    = $clog2(DEPTH);
    localparam int CW    = $clog2(DEPTH + 1);
    localparam int BW    = $clog2(BURST);
    localparam int TOK_W = $bits(acqr_pkg::acqr_token_t);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || BURST < 2 || (BURST & (BURST - 1)) != 0)
    begin : g_bad_param
        $error("DEPTH and BURST must be powers of two, at least 2");
    end

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_EMIT,
        ST_TERM,
        ST_CAL_WORD,
        ST_CAL_EOL,
        ST_STAT_SCANS,
        ST_STAT_BLOCKS,
        ST_STAT_EOL
    } acqr_state_t;

    acqr_state_t                  state;
    acqr_pkg::acqr_sample_t       acq_mem [DEPTH];
    logic [acqr_pkg::DATA_W-1:0]  cal_mem [acqr_pkg::CAL_MEM_WORDS];
    logic [AW-1:0]                wr_ptr;
    logic [AW-1:0]                rd_ptr;
    logic [CW-1:0]                count;
    logic [CW-1:0]                scan_cnt;
    logic [CW-1:0]                block_cnt;
    logic [CW-1:0]                rem;
    logic [BW-1:0]                smp_cnt;
    logic [acqr_pkg::RESP_W-1:0]  widx;
    logic                         by_block;
    logic                         last_eob;
    logic                         pres_s1;
    logic                         pres_s2;
    logic                         take;
    logic                         wr;
    logic                         pop;
    logic                         push_v;
    logic                         push;
    logic                         buf_ready;
    logic                         buf_empty;
    logic                         eos_in;
    logic                         enough;
    acqr_pkg::acqr_sample_t       rd_word;
    acqr_pkg::acqr_token_t        tok;

    // Line breaks of the card response: identity, eight gain lines, sensors, time/date
    function automatic logic cal_eol(input logic [acqr_pkg::RESP_W-1:0] w);
        cal_eol = (w <= 6'(acqr_pkg::CAL_CJ_IDX) && (w % 6'h03) == 6'h02)
               || w == 6'(acqr_pkg::CAL_TIME_IDX)
               || w == 6'(acqr_pkg::RESP_LAST);
    endfunction

    function automatic logic [CW-1:0] step(input logic [CW-1:0] v, input logic up,
                                           input logic dn);
        step = v + CW'(up) - CW'(dn);
    endfunction

    // ==========================================================
    // Card presence pin synchroniser
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            pres_s1 <= 1'b0;
            pres_s2 <= 1'b0;
        end else begin
            pres_s1 <= i_card_present;
            pres_s2 <= pres_s1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_cal_we) begin
            cal_mem[i_cal_addr] <= i_cal_data;
        end
    end

    // ==========================================================
    // Acquisition buffer
    assign wr      = i_acq_valid && o_acq_ready;
    assign eos_in  = i_acq.end_scan || i_acq.end_block
                  || (i_burst_mode && smp_cnt == BW'(BURST - 1)); // R15
    assign rd_word = acq_mem[rd_ptr]; // R10
    assign pop     = (state == ST_EMIT) && push;

    always_ff @(posedge i_clk) begin
        if (wr) begin
            acq_mem[wr_ptr] <= '{data: i_acq.data, end_scan: eos_in, end_block: i_acq.end_block};
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            smp_cnt <= '0;
        end else if (!i_burst_mode) begin
            smp_cnt <= '0;
        end else if (wr) begin
            smp_cnt <= smp_cnt + BW'(1); // R15
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            wr_ptr      <= '0;
            rd_ptr      <= '0;
            count       <= '0;
            scan_cnt    <= '0;
            block_cnt   <= '0;
            o_acq_ready <= 1'b0;
        end else begin
            wr_ptr      <= wr_ptr + AW'(wr);
            rd_ptr      <= rd_ptr + AW'(pop); // R11
            count       <= step(count, wr, pop);
            scan_cnt    <= step(scan_cnt, wr && eos_in, pop && rd_word.end_scan);
            block_cnt   <= step(block_cnt, wr && i_acq.end_block, pop && rd_word.end_block);
            o_acq_ready <= step(count, wr, pop) < CW'(DEPTH);
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_scan_avail <= 1'b0;
            o_scan_count <= '0;
        end else begin
            o_scan_avail <= scan_cnt != '0;
            o_scan_count <= scan_cnt; // R16
        end
    end

    // ==========================================================
    // Command intake
    assign take = i_cmd_valid && o_cmd_ready;

    always_comb begin
        case (i_cmd.rtype)
            acqr_pkg::RTYPE_OLDEST_SCAN:  enough = scan_cnt != '0;
            acqr_pkg::RTYPE_OLDEST_BLOCK: enough = block_cnt != '0;
            acqr_pkg::RTYPE_ALL_SCANS:    enough = scan_cnt != '0;
            default:                      enough = 1'b0;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            o_cmd_ready <= 1'b0;
            o_conflict  <= 1'b0;
        end else begin
            o_cmd_ready <= (state == ST_IDLE) && !take && buf_empty; // R13
            o_conflict  <= take && i_cmd.op == acqr_pkg::ACQR_OP_READ && !enough; // R14
        end
    end

    // ==========================================================
    // Response sequencer
    always_ff @(posedge i_clk) begin
        if (!i_nrst) begin
            state    <= ST_IDLE;
            rem      <= '0;
            widx     <= '0;
            by_block <= 1'b0;
            last_eob <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (take) begin
                        widx <= '0;
                        case (i_cmd.op)
                            acqr_pkg::ACQR_OP_CAL_QUERY: state <= ST_CAL_WORD;
                            acqr_pkg::ACQR_OP_BUF_QUERY: state <= ST_STAT_SCANS;
                            acqr_pkg::ACQR_OP_READ: begin
                                if (enough) begin
                                    state    <= ST_EMIT;
                                    by_block <= i_cmd.rtype == acqr_pkg::RTYPE_OLDEST_BLOCK; // R08
                                    rem      <= (i_cmd.rtype == acqr_pkg::RTYPE_ALL_SCANS)
                                              ? scan_cnt : CW'(1); // R07 R09
                                end
                            end
                            default: state <= ST_IDLE;
                        endcase
                    end
                end
                ST_EMIT: begin
                    if (push && rd_word.end_scan) begin
                        last_eob <= rd_word.end_block;
                        state    <= ST_TERM; // R12
                    end
                end
                ST_TERM: begin
                    if (push) begin
                        if (by_block ? last_eob : rem == CW'(1)) begin
                            state <= ST_IDLE;
                        end else begin
                            rem   <= rem - CW'(1);
                            state <= ST_EMIT;
                        end
                    end
                end
                ST_CAL_WORD: begin
                    if (push) begin
                        widx  <= widx + 6'h01;
                        state <= cal_eol(widx) ? ST_CAL_EOL : ST_CAL_WORD; // R06
                    end
                end
                ST_CAL_EOL: begin
                    if (push) begin
                        state <= (widx > 6'(acqr_pkg::RESP_LAST)) ? ST_IDLE : ST_CAL_WORD;
                    end
                end
                ST_STAT_SCANS: begin
                    if (push) begin
                        state <= ST_STAT_BLOCKS;
                    end
                end
                ST_STAT_BLOCKS: begin
                    if (push) begin
                        state <= ST_STAT_EOL;
                    end
                end
                ST_STAT_EOL: begin
                    if (push) begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // Token selection for the output queue
    always_comb begin
        push_v    = 1'b1;
        tok.kind  = acqr_pkg::ACQR_TOK_DATA;
        tok.data  = '0;
        case (state)
            ST_EMIT: tok.data = rd_word.data;
            ST_TERM: tok.kind = last_eob ? acqr_pkg::ACQR_TOK_BLOCK_END
                                         : acqr_pkg::ACQR_TOK_SCAN_END; // R18
            ST_CAL_WORD: begin
                if (widx == '0) begin
                    tok.data = acqr_pkg::DATA_W'(i_card_num); // R01
                end else if (widx == 6'(acqr_pkg::CAL_ID_IDX + 1) && !pres_s2) begin
                    tok.data = acqr_pkg::CARD_ABSENT_ID; // R05
                end else begin
                    tok.data = cal_mem[acqr_pkg::CAL_ADDR_W'(widx - 6'h01)]; // R02 R03 R04
                end
            end
            ST_CAL_EOL, ST_STAT_EOL: tok.kind = acqr_pkg::ACQR_TOK_LINE_END;
            ST_STAT_SCANS:  tok.data = acqr_pkg::DATA_W'(scan_cnt); // R16
            ST_STAT_BLOCKS: tok.data = acqr_pkg::DATA_W'(block_cnt);
            default: push_v = 1'b0;
        endcase
    end

    assign push = push_v && buf_ready; // R12

    acqr_skid #(
        .W (TOK_W)
    ) u_queue (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_valid (push_v),
        .i_data  (tok),
        .o_ready (buf_ready),
        .o_valid (o_out_valid),
        .o_data  (o_out),
        .i_ready (i_out_ready),
        .o_empty (buf_empty)
    );

    // ==========================================================
    // Checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    read_conflict_a: assert property (                                   // R14
        take && i_cmd.op == acqr_pkg::ACQR_OP_READ && scan_cnt == '0
        |=> o_conflict && state == ST_IDLE)
        else $error("read of empty buffer did not flag conflict");

    cmd_only_idle_a: assert property (                                   // R13
        o_cmd_ready |-> state == ST_IDLE && buf_empty)
        else $error("command accepted while queue busy");

    absent_card_id_a: assert property (                                  // R05
        push && state == ST_CAL_WORD && widx == 6'h02 && !pres_s2
        |-> tok.data == 32'hFFFFFFFF)
        else $error("absent card not reported as minus one");

    fifo_count_a: assert property (                                      // R11
        1'b1 |=> count == $past(count) + CW'($past(wr)) - CW'($past(pop)))
        else $error("buffer occupancy miscounted");

    fifo_order_a: assert property (                                      // R10
        pop ##1 (state == ST_EMIT || state == ST_TERM) |-> rd_ptr == $past(rd_ptr) + AW'(1))
        else $error("buffer read out of order");

    scan_term_a: assert property (                                       // R18
        pop && rd_word.end_scan |=> state == ST_TERM && last_eob == $past(rd_word.end_block))
        else $error("scan not followed by its terminator");

    burst_scan_a: assert property (                                      // R15
        wr && i_burst_mode && smp_cnt == BW'(BURST - 1) |=> scan_cnt != '0)
        else $error("burst unit not counted as a scan");

    type_all_a: assert property (                                        // R09
        take && i_cmd.op == acqr_pkg::ACQR_OP_READ && i_cmd.rtype == 2'h3 && scan_cnt != '0
        |=> state == ST_EMIT && rem == $past(scan_cnt) && !by_block)
        else $error("read-all did not take every scan");

    type_one_a: assert property (                                        // R07
        take && i_cmd.op == acqr_pkg::ACQR_OP_READ && i_cmd.rtype == 2'h1 && scan_cnt != '0
        |=> rem == CW'(1) && state == ST_EMIT)
        else $error("single scan read not set up");

    cal_tail_a: assert property (                                        // R06
        push && state == ST_CAL_WORD && widx == 6'h20
        |=> state == ST_CAL_EOL ##[1:64] state == ST_IDLE)
        else $error("card response did not end after date line");

    out_hold_a: assert property (                                        // R12
        o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out))
        else $error("queued word dropped before taken");

endmodule

// ---- sim/acqr_host.sv ----
module acqr_host (
    input  logic                  i_clk,
    input  logic                  i_nrst,
    input  logic                  i_out_valid,
    input  acqr_pkg::acqr_token_t i_out,
    output logic                  o_out_ready
);
    timeunit 1ns;
    timeprecision 1ps;

    // ==========================================================
    // Host side of the output queue: random stalls, tokens kept in order
    acqr_pkg::acqr_token_t got[$];

    initial o_out_ready = 1'b0;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            o_out_ready <= 1'b0;
        end else begin
            if (i_out_valid && o_out_ready) begin
                got.push_back(i_out);
            end
            o_out_ready <= ($urandom_range(3) != 0);
        end
    end
endmodule

// ---- sim/acqr_engine_bench.sv ----
module acqr_engine_bench;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int DEPTH = 16;
    localparam int BURST = 4;

    logic                   i_clk          = 1'b0;
    logic                   i_nrst         = 1'b0;
    logic                   i_cmd_valid    = 1'b0;
    acqr_pkg::acqr_cmd_t    i_cmd          = '0;
    logic                   i_acq_valid    = 1'b0;
    acqr_pkg::acqr_sample_t i_acq          = '0;
    logic                   i_burst_mode   = 1'b0;
    logic                   i_card_present = 1'b0;
    logic [7:0]             i_card_num     = 8'h00;
    logic                   i_cal_we       = 1'b0;
    logic [4:0]             i_cal_addr     = 5'h00;
    logic [31:0]            i_cal_data     = 32'h0;
    logic                   o_cmd_ready;
    logic                   o_conflict;
    logic                   o_acq_ready;
    logic                   o_out_valid;
    acqr_pkg::acqr_token_t  o_out;
    logic                   out_ready;
    logic                   o_scan_avail;
    logic [4:0]             o_scan_count;
    int                     err_total      = 0;
    int                     n_checks       = 0;
    int                     bcnt           = 0;
    logic [31:0]            cal[32];
    acqr_pkg::acqr_sample_t mq[$];
    acqr_pkg::acqr_token_t  exp_q[$];

    acqr_engine #(.DEPTH(DEPTH), .BURST(BURST)) dut (
        .i_clk          (i_clk),
        .i_nrst         (i_nrst),
        .i_cmd_valid    (i_cmd_valid),
        .i_cmd          (i_cmd),
        .o_cmd_ready    (o_cmd_ready),
        .o_conflict     (o_conflict),
        .i_acq_valid    (i_acq_valid),
        .i_acq          (i_acq),
        .o_acq_ready    (o_acq_ready),
        .i_burst_mode   (i_burst_mode),
        .i_card_present (i_card_present),
        .i_card_num     (i_card_num),
        .i_cal_we       (i_cal_we),
        .i_cal_addr     (i_cal_addr),
        .i_cal_data     (i_cal_data),
        .o_out_valid    (o_out_valid),
        .o_out          (o_out),
        .i_out_ready    (out_ready),
        .o_scan_avail   (o_scan_avail),
        .o_scan_count   (o_scan_count)
    );

    acqr_host host (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_out_valid (o_out_valid),
        .i_out       (o_out),
        .o_out_ready (out_ready)
    );

    initial forever #4 i_clk = ~i_clk;

    // ==========================================================
    // Compare and report
    task automatic complete_run();
        if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_val(string what, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic chk_tok(acqr_pkg::acqr_token_t e, acqr_pkg::acqr_token_t g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch token expected %h seen %h", e, g);
        end
    endtask

    // ==========================================================
    // Model of the acquisition buffer and the command responses
    task automatic put(acqr_pkg::acqr_kind_t k, logic [31:0] d);
        exp_q.push_back('{kind: k, data: d});
    endtask

    task automatic cnt(output int sc, output int bk);
        sc = 0;
        bk = 0;
        foreach (mq[i]) begin
            sc += int'(mq[i].end_scan);
            bk += int'(mq[i].end_block);
        end
    endtask

    task automatic wr(logic [31:0] d, logic es, logic eb);
        logic e;
        e = es | eb | (i_burst_mode && bcnt == BURST - 1);
        bcnt = (!i_burst_mode || e) ? 0 : bcnt + 1;
        i_acq_valid <= 1'b1;
        i_acq       <= '{data: d, end_scan: es, end_block: eb};
        do @(posedge i_clk); while (o_acq_ready !== 1'b1);
        mq.push_back('{data: d, end_scan: e, end_block: eb});
    endtask

    task automatic scan(int len, logic blk);
        for (int i = 1; i <= len; i++) begin
            wr($urandom, i == len, blk && i == len);
        end
    endtask

    task automatic settle();
        int sc;
        int bk;
        i_acq_valid <= 1'b0;
        repeat (3) @(posedge i_clk);
        cnt(sc, bk);
        chk_val("scan_count", 32'(sc), 32'(o_scan_count));
        chk_val("scan_avail", 32'(sc != 0), 32'(o_scan_avail));
    endtask

    task automatic cmd(acqr_pkg::acqr_op_t op, logic [1:0] rt, logic cf);
        int n;
        host.got.delete();
        i_cmd_valid <= 1'b1;
        i_cmd       <= '{op: op, rtype: rt};
        do @(posedge i_clk); while (o_cmd_ready !== 1'b1);
        i_cmd_valid <= 1'b0;
        @(posedge i_clk);
        chk_val("conflict", 32'(cf), 32'(o_conflict));
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_cmd_ready !== 1'b1 && n < 600);
        chk_val("cmd_ready", 32'h1, 32'(o_cmd_ready));
        chk_val("tokens", 32'(exp_q.size()), 32'(host.got.size()));
        foreach (exp_q[i]) begin
            if (i < host.got.size()) chk_tok(exp_q[i], host.got[i]);
        end
        exp_q.delete();
    endtask

    task automatic rd(logic [1:0] rt);
        acqr_pkg::acqr_sample_t s;
        int                     sc;
        int                     bk;
        int                     n;
        logic                   cf;
        cnt(sc, bk);
        cf = rt == 2'h0 || (rt != 2'h2 && sc == 0) || (rt == 2'h2 && bk == 0);
        n = (rt == 2'h3) ? sc : 1;
        while (!cf && n > 0) begin
            s = mq.pop_front();
            put(acqr_pkg::ACQR_TOK_DATA, s.data);
            if (s.end_scan) begin
                put(s.end_block ? acqr_pkg::ACQR_TOK_BLOCK_END : acqr_pkg::ACQR_TOK_SCAN_END, 0);
                n -= (rt != 2'h2 || s.end_block) ? 1 : 0;
            end
        end
        cmd(acqr_pkg::ACQR_OP_READ, rt, cf);
    endtask

    task automatic bufq();
        int sc;
        int bk;
        cnt(sc, bk);
        put(acqr_pkg::ACQR_TOK_DATA, sc);
        put(acqr_pkg::ACQR_TOK_DATA, bk);
        put(acqr_pkg::ACQR_TOK_LINE_END, 0);
        cmd(acqr_pkg::ACQR_OP_BUF_QUERY, 2'h0, 1'b0);
    endtask

    task automatic calq();
        put(acqr_pkg::ACQR_TOK_DATA, {24'h0, i_card_num});
        for (int k = 0; k < 32; k++) begin
            put(acqr_pkg::ACQR_TOK_DATA, (k == 1 && !i_card_present) ? 32'hFFFFFFFF : cal[k]);
            if (k == 1 || (k >= 4 && k <= 25 && (k - 1) % 3 == 0) || k == 29 || k == 31) begin
                put(acqr_pkg::ACQR_TOK_LINE_END, 0);
            end
        end
        cmd(acqr_pkg::ACQR_OP_CAL_QUERY, 2'h0, 1'b0);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        repeat (20000) @(posedge i_clk);
        err_total++;
        complete_run();
    end

    initial begin
        void'($urandom(32'h6F89));
        repeat (4) @(posedge i_clk);
        i_nrst <= 1'b1;
        repeat (2) @(posedge i_clk);
        settle();
        for (int k = 0; k < 32; k++) begin
            i_cal_we   <= 1'b1;
            i_cal_addr <= 5'(k);
            i_cal_data <= $urandom;
            @(posedge i_clk);
            cal[k] = i_cal_data;
        end
        i_cal_we       <= 1'b0;
        i_card_num     <= 8'($urandom);
        i_card_present <= 1'b1;
        repeat (4) @(posedge i_clk);
        calq();
        i_card_present <= 1'b0;
        repeat (4) @(posedge i_clk);
        calq();
        rd(2'h0);
        rd(2'h1);
        repeat (2) scan($urandom_range(1, 3), 1'b0);
        settle();
        rd(2'h2);
        scan(3, 1'b1);
        scan(2, 1'b0);
        scan(1, 1'b1);
        settle();
        bufq();
        while (o_scan_avail !== 1'b1) @(posedge i_clk);
        rd(2'h1);
        rd(2'h2);
        bufq();
        rd(2'h3);
        rd(2'h3);
        i_burst_mode <= 1'b1;
        @(posedge i_clk);
        repeat (2 * BURST + 1) wr($urandom, 1'b0, 1'b0);
        i_burst_mode <= 1'b0;
        settle();
        rd(2'h3);
        wr($urandom, 1'b1, 1'b0);
        settle();
        rd(2'h1);
        repeat (DEPTH) wr($urandom, 1'b1, 1'($urandom_range(1)));
        i_acq <= '{data: $urandom, end_scan: 1'b1, end_block: 1'b0};
        repeat (3) @(posedge i_clk);
        chk_val("acq_ready", 32'h0, 32'(o_acq_ready));
        settle();
        rd(2'h3);
        bufq();
        complete_run();
    end
endmodule
